//--- shared/bir_params.svh
// Offsets, field positions, reset values and timing counts of the router.
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH
`define BIR_OFF_ENABLE 8'h00
`define BIR_OFF_ROUTE 8'h04
`define BIR_OFF_STATUS 8'h08
`define BIR_OFF_SOFT 8'h0c
`define BIR_OFF_IACK 8'h10
`define BIR_OFF_MISC 8'h14
`define BIR_EV_OPNE 0
`define BIR_EV_IPN 1
`define BIR_EV_IFE 2
`define BIR_EV_OFE 3
`define BIR_EV_IPF 4
`define BIR_EV_OFF 5
`define BIR_EV_PCSR 6
`define BIR_EV_SI0 7
`define BIR_NUM_EV 11
`define BIR_NUM_GATED 7
`define BIR_INT_PIN_RST 8'h01
`define BIR_INT_LINE_RST 8'h00
`define BIR_INT_PIN_LSB 8
`define BIR_ACK_TIMEOUT_NS 2560
`define BIR_CLK_NS 10
`define BIR_ACK_TIMEOUT_CYC (`BIR_ACK_TIMEOUT_NS / `BIR_CLK_NS)
`endif

//--- shared/bir_pkg.sv
// Types used by the interrupt router and its ack state machine.
package bir_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bir_req_t;
  typedef struct packed {
    logic go;
    logic [31:0] addr;
    logic [3:0] be;
  } bir_ack_req_t;
  typedef enum logic [1:0] {
    BIR_IDLE,
    BIR_BUSY,
    BIR_HAVE
  } bir_ack_state_t;
endpackage : bir_pkg

//--- logic/bir_flag.sv
// One sticky status flag with write-one-to-clear and set priority.
`timescale 1ns/1ns
module bir_flag (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  typedef struct packed {
    logic flag;
  } bir_flag_st_t;
  bir_flag_st_t st;
  bir_flag_st_t next_st;

  // Set wins over a clear arriving in the same cycle.
  always_comb begin
    next_st = st;
    if (set_i) begin
      next_st.flag = 1'b1;
    end else if (clr_i) begin
      next_st.flag = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign flag_o = st.flag;
endmodule : bir_flag

//--- logic/bir_router.sv
// Interrupt router of a PCI to local processor bus bridge.
// Summary of operation
// - Six list events, each enable, route, status.
// - Inbound post new entry raises gated routed event.
// - Four software sources set status and irq.
// - Software interrupts bypass enable gating.
// - Line held while flag set; write-one clears.
// - Interrupts never stall the other channel.
// - Five PCI status flags set summary flag.
// - Summary interrupt routed by own route bit.
// - Master parity flag excluded from summary.
// - Write one clears summary flag and interrupt.
// - Local read of ack register starts cycle.
// - Byte enables from size and address bits.
// - Local address passes unchanged to PCI.
// - Retry ack reads until vector latched.
// - Latched vector returned on next retry.
// - Ack writes ignored; PCI reads return zero.
// - Interrupt pin field resets to one.
// - Pin field loadable at reset or written.
// - Pin field never gates PCI interrupt.
// - Line field read-write, resets to zero.
// - Each event routed to one of two outputs.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "bir_params.svh"
module bir_router import bir_pkg::*; #(
  parameter int NUM_SOFT = 4,
  parameter int NUM_LIST = 6
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NUM_LIST-1:0] list_event_i,
  input wire logic [4:0] pci_status_flags_i,
  input wire logic master_parity_detected_i,
  input wire logic eeprom_pin_valid_i,
  input wire logic [7:0] eeprom_pin_i,
  input wire logic pci_cfg_rd_i,
  input wire logic [7:0] pci_cfg_addr_i,
  output logic [31:0] pci_cfg_rdata_o,
  input wire logic iack_rd_i,
  input wire logic [31:0] iack_addr_i,
  input wire logic [1:0] local_xfer_size_i,
  output logic iack_retry_o,
  output logic iack_done_o,
  output logic [31:0] iack_rdata_o,
  output logic pci_iack_go_o,
  output logic [31:0] pci_iack_addr_o,
  output logic [3:0] pci_iack_be_o,
  input wire logic pci_iack_done_i,
  input wire logic [31:0] pci_iack_vector_i,
  output logic pci_irq_out_n_o,
  output logic local_irq_out_n_o
);
  localparam int NEV = `BIR_NUM_EV;

  initial begin
    if (NUM_SOFT != 4 || NUM_LIST != 6) begin
      $error("bir_router: event layout supports 4 soft and 6 list events");
    end
  end

  typedef struct packed {
    logic [NEV-1:0] enable;
    logic [NEV-1:0] route;
    logic [NUM_SOFT-1:0] soft_src;
    logic [7:0] int_pin;
    logic [7:0] int_line;
    logic [31:0] vector;
    bir_ack_state_t ack_st;
    bir_ack_req_t ack;
    logic [31:0] rdata;
    logic [31:0] cfg_rdata;
    logic pci_irq_n;
    logic local_irq_n;
    logic [4:0] pci_prev;
  } bir_st_t;
  bir_st_t st;
  bir_st_t next_st;

  bir_req_t req;
  logic [NEV-1:0] flag;
  logic [NEV-1:0] set_ev;
  logic [NEV-1:0] clr_ev;
  logic [NEV-1:0] live;
  logic [NEV-1:0] gate;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  //////////////////////////////////////////////////////////////////////////
  // Event sources and clears.
  always_comb begin
    set_ev = '0;
    set_ev[NUM_LIST-1:0] = list_event_i & st.enable[NUM_LIST-1:0];
    set_ev[`BIR_EV_PCSR] = st.enable[`BIR_EV_PCSR]
                          & (|(pci_status_flags_i & ~st.pci_prev));
    set_ev[NEV-1:`BIR_EV_SI0] = st.soft_src;
    clr_ev = (req.wr && req.addr == `BIR_OFF_STATUS)
             ? req.wdata[NEV-1:0] : '0;
  end

  assign live = {st.soft_src, 1'b0, list_event_i};

  //////////////////////////////////////////////////////////////////////////
  // Sticky status flags; a level source holding high re-sets its flag.
  for (genvar g = 0; g < NEV; g++) begin : g_flag
    bir_flag u_flag (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .set_i(set_ev[g] | (live[g] & (g >= `BIR_NUM_GATED
                                     || st.enable[g]))),
      .clr_i(clr_ev[g]),
      .flag_o(flag[g])
    );
  end

  assign gate = flag & (st.enable | (NEV'({NUM_SOFT{1'b1}}) << `BIR_EV_SI0));

  //////////////////////////////////////////////////////////////////////////
  // Register, acknowledge and output logic.
  always_comb begin
    next_st = st;
    next_st.pci_prev = pci_status_flags_i;
    next_st.ack.go = 1'b0;
    next_st.rdata = '0;
    next_st.cfg_rdata = '0;
    // Register writes.
    if (req.wr) begin
      unique case (req.addr)
        `BIR_OFF_ENABLE: next_st.enable = req.wdata[NEV-1:0];
        `BIR_OFF_ROUTE: next_st.route = req.wdata[NEV-1:0];
        `BIR_OFF_SOFT: next_st.soft_src = req.wdata[NUM_SOFT-1:0];
        `BIR_OFF_MISC: begin
          next_st.int_line = req.wdata[7:0];
          next_st.int_pin = req.wdata[`BIR_INT_PIN_LSB+:8];
        end
        default: ;
      endcase
    end
    if (eeprom_pin_valid_i) begin
      next_st.int_pin = eeprom_pin_i;
    end
    // Register reads answer one cycle later; unmapped reads give zero.
    if (req.rd) begin
      unique case (req.addr)
        `BIR_OFF_ENABLE: next_st.rdata[NEV-1:0] = st.enable;
        `BIR_OFF_ROUTE: next_st.rdata[NEV-1:0] = st.route;
        `BIR_OFF_STATUS: next_st.rdata[NEV-1:0] = flag;
        `BIR_OFF_SOFT: next_st.rdata[NUM_SOFT-1:0] = st.soft_src;
        `BIR_OFF_IACK: next_st.rdata = st.vector;
        `BIR_OFF_MISC: next_st.rdata[15:0] = {st.int_pin, st.int_line};
        default: ;
      endcase
    end
    if (pci_cfg_rd_i && pci_cfg_addr_i == `BIR_OFF_MISC) begin
      next_st.cfg_rdata[15:0] = {st.int_pin, st.int_line};
    end
    unique case (st.ack_st)
      BIR_IDLE: begin
        if (iack_rd_i) begin
          next_st.ack_st = BIR_BUSY;
          next_st.ack.go = 1'b1;
          next_st.ack.addr = iack_addr_i;
          next_st.ack.be = be_of(local_xfer_size_i, iack_addr_i[1:0]);
        end
      end
      BIR_BUSY: begin
        if (pci_iack_done_i) begin
          next_st.vector = pci_iack_vector_i;
          next_st.ack_st = BIR_HAVE;
        end
      end
      BIR_HAVE: begin
        if (iack_rd_i) begin
          next_st.ack_st = BIR_IDLE;
        end
      end
      // The unused state code falls back to idle.
      default: begin
        next_st.ack_st = BIR_IDLE;
      end
    endcase
    next_st.pci_irq_n = ~|(gate & ~st.route);
    next_st.local_irq_n = ~|(gate & st.route);
  end

  // Byte lanes: size 0 is a word, 1 a byte, 2 a halfword, 3 three bytes.
  function automatic logic [3:0] be_of(input logic [1:0] siz,
                                       input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    unique case (siz)
      2'h0: m = 4'hf;
      2'h1: m = 4'h1;
      2'h2: m = 4'h3;
      2'h3: m = 4'h7;
    endcase
    be_of = 4'((m << a) & 4'hf);
  endfunction : be_of

  // State register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.int_pin <= `BIR_INT_PIN_RST;
      st.int_line <= `BIR_INT_LINE_RST;
      st.pci_irq_n <= 1'b1;
      st.local_irq_n <= 1'b1;
      st.ack_st <= BIR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.
  // no cross-channel stall
  assign rdata_o = st.rdata;
  assign pci_cfg_rdata_o = st.cfg_rdata;
  assign iack_retry_o = iack_rd_i && st.ack_st != BIR_HAVE;
  assign iack_done_o = iack_rd_i && st.ack_st == BIR_HAVE;
  assign iack_rdata_o = st.vector;
  assign pci_iack_go_o = st.ack.go;
  assign pci_iack_addr_o = st.ack.addr;
  assign pci_iack_be_o = st.ack.be;
  assign pci_irq_out_n_o = st.pci_irq_n;
  assign local_irq_out_n_o = st.local_irq_n;
endmodule : bir_router

//--- tb/bir_router_checker.sv
// Port assertions of the interrupt router.
`timescale 1ns/1ns
`include "bir_params.svh"
module bir_router_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pci_cfg_rd_i,
  input wire logic [7:0] pci_cfg_addr_i,
  input wire logic [31:0] pci_cfg_rdata_o,
  input wire logic iack_rd_i,
  input wire logic [31:0] iack_addr_i,
  input wire logic [1:0] local_xfer_size_i,
  input wire logic iack_retry_o,
  input wire logic iack_done_o,
  input wire logic [31:0] iack_rdata_o,
  input wire logic pci_iack_go_o,
  input wire logic [31:0] pci_iack_addr_o,
  input wire logic [3:0] pci_iack_be_o,
  input wire logic pci_iack_done_i,
  input wire logic [31:0] pci_iack_vector_i
);
  logic [31:0] vec;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Keeps the last vector returned by the PCI target.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) vec <= 32'h0;
    else if (pci_iack_done_i) vec <= pci_iack_vector_i;
  end
  // Lane mask from transfer size, shifted by the low address bits.
  function automatic logic [3:0] be_of(logic [1:0] s, logic [1:0] a);
    logic [3:0] m;
    m = (s == 2'h0) ? 4'hf : (4'h1 << s) - 4'h1;
    return m << a;
  endfunction : be_of
  // A local attempt followed by the start of the PCI cycle.
  sequence s_go;
    iack_rd_i ##1 $rose(pci_iack_go_o);
  endsequence
  a_go_cause: assert property ($rose(pci_iack_go_o) |-> $past(iack_rd_i))
    else $error("ack cycle without local read");
  a_addr_pass: assert property (s_go |-> pci_iack_addr_o == $past(iack_addr_i))
    else $error("ack address changed");
  a_be_map: assert property (s_go |-> pci_iack_be_o ==
    be_of($past(local_xfer_size_i), $past(iack_addr_i[1:0])))
    else $error("ack byte enables wrong");
  a_ack_excl: assert property (!(iack_retry_o && iack_done_o))
    else $error("retry and done together");
  a_retry_busy: assert property (s_go ##1 iack_rd_i |-> iack_retry_o)
    else $error("attempt not retried while busy");
  a_done_vec: assert property (iack_done_o |-> iack_rd_i && iack_rdata_o == vec)
    else $error("wrong vector returned");
  a_new_cycle: assert property (iack_done_o ##2 iack_rd_i |-> iack_retry_o)
    else $error("next attempt not retried");
  a_cfg_zero: assert property (pci_cfg_rd_i && pci_cfg_addr_i == `BIR_OFF_IACK
    |=> pci_cfg_rdata_o == 32'h0)
    else $error("PCI read of ack not zero");
endmodule : bir_router_checker
bind bir_router bir_router_checker u_chk (.clk_i, .arst_n_i, .pci_cfg_rd_i,
  .pci_cfg_addr_i, .pci_cfg_rdata_o, .iack_rd_i, .iack_addr_i,
  .local_xfer_size_i, .iack_retry_o, .iack_done_o, .iack_rdata_o,
  .pci_iack_go_o, .pci_iack_addr_o, .pci_iack_be_o, .pci_iack_done_i,
  .pci_iack_vector_i);

//--- tb/bir_pci_target.sv
// PCI target model answering interrupt acknowledge cycles.
`timescale 1ns/1ns
module bir_pci_target (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic go_i,
  input wire logic [3:0] lat_i,
  input wire logic [31:0] vec_i,
  output logic done_o,
  output logic [31:0] vector_o
);
  logic [4:0] cnt;
  // Answers lat_i + 2 cycles after a request; idle data toggles every cycle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 5'h0;
      done_o <= 1'b0;
      vector_o <= 32'h0;
    end else begin
      done_o <= (cnt == 5'h1);
      vector_o <= (cnt == 5'h1) ? vec_i : ~vector_o;
      if (go_i) cnt <= {1'b0, lat_i} + 5'h1;
      else if (cnt != 5'h0) cnt <= cnt - 5'h1;
    end
  end
endmodule : bir_pci_target

//--- tb/test_bir_router.sv
// Self-checking bench for the interrupt router.
`timescale 1ns/1ns
`include "bir_params.svh"
module test_bir_router;
  logic clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic master_parity_detected_i = 1'b0, eeprom_pin_valid_i = 1'b0;
  logic pci_cfg_rd_i = 1'b0, iack_rd_i = 1'b0, got = 1'b0;
  logic [7:0] addr_i = 8'h0, eeprom_pin_i = 8'h0, pci_cfg_addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0, iack_addr_i = 32'h0, vec = 32'h0;
  logic [5:0] list_event_i = 6'h0;
  logic [4:0] pci_status_flags_i = 5'h0;
  logic [1:0] local_xfer_size_i = 2'h0;
  logic [3:0] lat = 4'h0, pci_iack_be_o;
  logic [31:0] rdata_o, pci_cfg_rdata_o, iack_rdata_o, pci_iack_addr_o;
  logic [31:0] pci_iack_vector_i;
  logic iack_retry_o, iack_done_o, pci_iack_go_o, pci_iack_done_i;
  logic pci_irq_out_n_o, local_irq_out_n_o;
  int err_count = 0, tests_run = 0, b;
  always #5 clk_i = ~clk_i;
  bir_router dut (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .list_event_i, .pci_status_flags_i, .master_parity_detected_i,
    .eeprom_pin_valid_i, .eeprom_pin_i, .pci_cfg_rd_i, .pci_cfg_addr_i,
    .pci_cfg_rdata_o, .iack_rd_i, .iack_addr_i, .local_xfer_size_i,
    .iack_retry_o, .iack_done_o, .iack_rdata_o, .pci_iack_go_o,
    .pci_iack_addr_o, .pci_iack_be_o, .pci_iack_done_i, .pci_iack_vector_i,
    .pci_irq_out_n_o, .local_irq_out_n_o);
  bir_pci_target u_pci (.clk_i, .arst_n_i, .go_i(pci_iack_go_o), .lat_i(lat),
    .vec_i(vec), .done_o(pci_iack_done_i), .vector_o(pci_iack_vector_i));
  ////////////////////////////////////////////////////////////////////////////
  // Compares and counts one value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Holds reset low for five cycles.
  task automatic reset;
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask : reset
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Local (p low) or PCI (p high) read, data checked a cycle later.
  task automatic rd(input logic p, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    pci_cfg_addr_i <= a;
    rd_i <= !p;
    pci_cfg_rd_i <= p;
    @(posedge clk_i);
    rd_i <= 1'b0;
    pci_cfg_rd_i <= 1'b0;
    #1 chk(p ? pci_cfg_rdata_o : rdata_o, e);
  endtask : rd
  // Checks both interrupt outputs.
  task automatic irq(input logic p, input logic l);
    #1 chk({30'h0, pci_irq_out_n_o, local_irq_out_n_o}, {30'h0, p, l});
  endtask : irq
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset;
    rd(1'b0, `BIR_OFF_MISC, 32'h100);
    irq(1'b1, 1'b1);
    wr(`BIR_OFF_MISC, 32'hff);
    rd(1'b0, `BIR_OFF_MISC, 32'hff);
    eeprom_pin_i <= 8'h02;
    eeprom_pin_valid_i <= 1'b1;
    @(posedge clk_i);
    eeprom_pin_valid_i <= 1'b0;
    rd(1'b0, `BIR_OFF_MISC, 32'h2ff);
    wr(`BIR_OFF_MISC, 32'hff);
    rd(1'b1, `BIR_OFF_MISC, 32'hff);
    rd(1'b1, `BIR_OFF_IACK, 32'h0);
    // masked and excluded sources stay quiet.
    wr(`BIR_OFF_ENABLE, 32'h40);
    master_parity_detected_i <= 1'b1;
    list_event_i <= 6'h3f;
    repeat (4) @(posedge clk_i);
    irq(1'b1, 1'b1);
    list_event_i <= 6'h0;
    wr(`BIR_OFF_STATUS, 32'h7ff);
    wr(`BIR_OFF_ENABLE, 32'h7f);
    for (int k = 0; k < 15; k++) begin
      b = (k < 6) ? k : (k < 11) ? 6 : k - 4;
      wr(`BIR_OFF_ROUTE, k[0] ? 32'h1 << b : 32'h0);
      if (k > 10) wr(`BIR_OFF_SOFT, 32'h1 << (k - 11));
      else begin
        @(posedge clk_i);
        list_event_i <= (k < 6) ? 6'h1 << k : 6'h0;
        pci_status_flags_i <= (k < 6) ? 5'h0 : 5'h1 << (k - 6);
      end
      @(posedge clk_i);
      list_event_i <= 6'h0;
      pci_status_flags_i <= 5'h0;
      wr(`BIR_OFF_SOFT, 32'h0);
      repeat (2) @(posedge clk_i);
      irq(k[0], ~k[0]);
      rd(1'b0, `BIR_OFF_STATUS, 32'h1 << b);
      wr(`BIR_OFF_STATUS, 32'h1 << b);
      rd(1'b0, `BIR_OFF_STATUS, 32'h0);
      irq(1'b1, 1'b1);
    end
    // attempts retried until the vector arrives.
    for (int j = 0; j < 16; j++) begin
      lat <= j[3:0];
      vec <= 32'h5a5a0000 + j;
      iack_addr_i <= 32'h10 | j[1:0];
      local_xfer_size_i <= j[3:2];
      got = 1'b0;
      for (int n = 0; n < 40 && !got; n++) begin
        @(posedge clk_i);
        iack_rd_i <= 1'b1;
        #1 got = (iack_done_o === 1'b1);
        if (got) chk(iack_rdata_o, vec);
        else chk({31'h0, iack_retry_o}, 32'h1);
        @(posedge clk_i);
        iack_rd_i <= 1'b0;
      end
      if (!got) begin
        err_count++;
        print_verdict;
      end
    end
    wr(`BIR_OFF_IACK, 32'h0);
    rd(1'b0, `BIR_OFF_IACK, vec);
    wr(`BIR_OFF_SOFT, 32'h1);
    reset;
    irq(1'b1, 1'b1);
    rd(1'b0, `BIR_OFF_MISC, 32'h100);
    print_verdict;
  end
endmodule : test_bir_router
